// file: logic/fcd_host.sv
/*
  Host-side command sequencer for an asynchronous parallel NOR flash.
  Turns one user command into the flash's unlock, command and data bus cycles,
  and tracks the overlay mode the device is left in by every command but a buffer abort, and its suspend state.
  Assumes the user holds a command until cmd_ready_o and the flash pins are
  driven straight from the bus-cycle engine.
*/
// Notes on behaviour
// - F0 anywhere returns device to array read
// - 70 at 555, next read returns status
// - 71 at 555 clears status register
// - word program: AA, 55, A0, address/data
// - buffered load: unlock, 25, count, word pairs
// - 29 at sector confirms buffer to array
// - abort reset: AA, 55, F0 at 555
// - chip erase: six cycles ending 10
// - sector erase: five cycles, then 30 at sector
// - B0 anywhere suspends program or erase
// - 30 anywhere resumes suspended operation
// - AA, 55, 90 in sector enters identification
// - 98 at 55 in sector shows query table
// - AA, 55, 88 in sector enters secure region
// - secure region uses same program sequences
// - secure exit: AA, 55, 90, then 0
`timescale 1ns/1ps
module fcd_host import fcd_pkg::*; #(
  parameter int AW = 26,
  parameter int DW = 16,
  parameter int CW = 8,
  parameter int SECT_LSB = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i,
  input wire fcd_op_t cmd_op_i,
  input wire logic [AW-1:0] cmd_addr_i,
  input wire logic [DW-1:0] cmd_data_i,
  input wire logic [CW-1:0] cmd_count_i,
  output logic cmd_ready_o,
  output logic word_req_o,
  input wire logic word_valid_i,
  input wire logic [AW-1:0] word_addr_i,
  input wire logic [DW-1:0] word_data_i,
  output logic [DW-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output fcd_mode_t overlay_space_mode_o,
  output logic suspended_o,
  output logic [AW-1:0] flash_addr_o,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DW-1:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (AW <= LOW_W || DW < 8 || CW < 1 || CW > DW) begin : g_bad_width
    $error("fcd_host: unsupported address, data or count width");
  end
  if (SECT_LSB < LOW_W || SECT_LSB >= AW) begin : g_bad_sector
    $error("fcd_host: sector boundary must lie above the unlock address bits");
  end

  // ----------------------------------------------------------------
  // step table
  // ----------------------------------------------------------------
  function automatic fcd_step_t wstep(input fcd_asel_t asel, input logic [7:0] code,
                                      input logic last);
    fcd_step_t s;
    s = '0;
    s.asel = asel;
    s.code = code;
    s.last = last;
    return s;
  endfunction

  // the two unlock cycles shared by most sequences
  function automatic fcd_step_t unlock_step(input logic [2:0] idx);
    return (idx[0] == 1'b0) ? wstep(A_UNLOCK1, CODE_UNLOCK1, 1'b0)
                            : wstep(A_UNLOCK2, CODE_UNLOCK2, 1'b0);
  endfunction

  function automatic fcd_step_t step_of(input fcd_op_t op, input logic [2:0] idx);
    fcd_step_t s;
    s = wstep(A_USER, CODE_RESET, 1'b1);
    case (op)
      OP_READ: begin
        s.rd = 1'b1;
      end
      OP_RESET: s = wstep(A_USER, CODE_RESET, 1'b1);
      OP_SR_READ: begin
        if (idx == 3'd0) begin
          s = wstep(A_UNLOCK1, CODE_SR_READ, 1'b0);
        end else begin
          s.rd = 1'b1;
        end
      end
      OP_SR_CLEAR: s = wstep(A_UNLOCK1, CODE_SR_CLEAR, 1'b1);
      OP_WORD_PROG: begin
        if (idx < 3'd2) begin
          s = unlock_step(idx);
        end else if (idx == 3'd2) begin
          s = wstep(A_UNLOCK1, CODE_PROGRAM, 1'b0);
        end else begin
          s.user_data = 1'b1;
        end
      end
      OP_BUF_PROG: begin
        if (idx < 3'd2) begin
          s = unlock_step(idx);
        end else if (idx == 3'd2) begin
          s = wstep(A_USER, CODE_BUF_LOAD, 1'b0);
        end else begin
          s = wstep(A_USER, CODE_SET_EXIT, 1'b0);
          s.count_data = 1'b1;
          s.words = 1'b1;
        end
      end
      OP_BUF_ABORT: begin
        s = (idx < 3'd2) ? unlock_step(idx) : wstep(A_UNLOCK1, CODE_RESET, 1'b1);
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        if (idx == 3'd2) begin
          s = wstep(A_UNLOCK1, CODE_ERASE_SETUP, 1'b0);
        end else if (idx < 3'd5) begin
          s = unlock_step((idx > 3'd2) ? idx - 3'd3 : idx);
        end else if (op == OP_CHIP_ERASE) begin
          s = wstep(A_UNLOCK1, CODE_CHIP_ERASE, 1'b1);
        end else begin
          s = wstep(A_USER, CODE_SECTOR_ERASE, 1'b1);
        end
      end
      OP_SUSPEND: s = wstep(A_USER, CODE_SUSPEND, 1'b1);
      OP_RESUME: s = wstep(A_USER, CODE_RESUME, 1'b1);
      OP_ID_ENTRY: begin
        s = (idx < 3'd2) ? unlock_step(idx) : wstep(A_SECT_UNLOCK1, CODE_ID_ENTRY, 1'b1);
      end
      OP_QUERY_ENTRY: s = wstep(A_SECT_QUERY, CODE_QUERY_ENTRY, 1'b1);
      OP_SECURE_ENTRY: begin
        s = (idx < 3'd2) ? unlock_step(idx)
                         : wstep(A_SECT_UNLOCK1, CODE_SECURE_ENTRY, 1'b1);
      end
      OP_SECURE_EXIT: begin
        if (idx < 3'd2) begin
          s = unlock_step(idx);
        end else if (idx == 3'd2) begin
          s = wstep(A_UNLOCK1, CODE_ID_ENTRY, 1'b0);
        end else begin
          s = wstep(A_USER, CODE_SET_EXIT, 1'b1);
        end
      end
      default: s = wstep(A_USER, CODE_RESET, 1'b1);
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_WORD, S_WWAIT, S_CONFIRM} fcd_state_t;

  fcd_state_t st_q;
  fcd_op_t op_q;
  logic [2:0] idx_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic [CW-1:0] count_q;
  logic [CW:0] left_q;
  logic confirm_q;
  logic req_q;
  logic [AW-1:0] cyc_addr_q;
  logic [DW-1:0] cyc_data_q;
  logic cyc_wr_q;

  fcd_cyc_if #(.AW(AW), .DW(DW)) cyc_bus ();

  assign cyc_bus.req = req_q;
  assign cyc_bus.wr = cyc_wr_q;
  assign cyc_bus.addr = cyc_addr_q;
  assign cyc_bus.wdata = cyc_data_q;

  // ----------------------------------------------------------------
  // step decode
  // ----------------------------------------------------------------
  wire fcd_step_t step_w = step_of(op_q, idx_q);
  wire [AW-SECT_LSB-1:0] sect_w = addr_q[AW-1:SECT_LSB];
  wire [AW-1:0] sect_unlock_w = {sect_w, (SECT_LSB - LOW_W)'(0), ADDR_UNLOCK1};
  wire [AW-1:0] sect_query_w = {sect_w, (SECT_LSB - LOW_W)'(0), ADDR_QUERY};
  wire [AW-1:0] step_addr_w =
    (step_w.asel == A_UNLOCK1) ? AW'(ADDR_UNLOCK1) :
    (step_w.asel == A_UNLOCK2) ? AW'(ADDR_UNLOCK2) :
    (step_w.asel == A_SECT_UNLOCK1) ? sect_unlock_w :
    (step_w.asel == A_SECT_QUERY) ? sect_query_w : addr_q;
  wire [DW-1:0] step_data_w =
    step_w.user_data ? data_q :
    step_w.count_data ? DW'(count_q) : DW'(step_w.code);
  wire take_cmd = cmd_valid_i && cmd_ready_o;
  wire take_word = word_valid_i && word_req_o;
  wire seq_done = (st_q == S_WAIT) && cyc_bus.done && (step_w.last || confirm_q);

  // mode the device is in once the finished sequence lands, but the old tracked mode after a buffer abort
  wire fcd_mode_t mode_next_w =
    (op_q == OP_RESET) ? MODE_ARRAY :
    (op_q == OP_ID_ENTRY || op_q == OP_QUERY_ENTRY) ? MODE_ID :
    (op_q == OP_SECURE_ENTRY) ? MODE_SECURE :
    (op_q == OP_SECURE_EXIT) ? MODE_ARRAY : overlay_space_mode_o;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
      idx_q <= 3'd0;
      addr_q <= '0;
      data_q <= '0;
      count_q <= '0;
      left_q <= '0;
      confirm_q <= 1'b0;
      req_q <= 1'b0;
      cyc_addr_q <= '0;
      cyc_data_q <= '0;
      cyc_wr_q <= 1'b0;
      cmd_ready_o <= 1'b1;
      word_req_o <= 1'b0;
    end else begin
      req_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (take_cmd) begin
            op_q <= cmd_op_i;
            addr_q <= cmd_addr_i;
            data_q <= cmd_data_i;
            count_q <= cmd_count_i;
            left_q <= {1'b0, cmd_count_i} + (CW + 1)'(1);
            idx_q <= 3'd0;
            confirm_q <= 1'b0;
            cmd_ready_o <= 1'b0;
            st_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          cyc_addr_q <= step_addr_w;
          cyc_data_q <= step_data_w;
          cyc_wr_q <= !step_w.rd;
          req_q <= 1'b1;
          st_q <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_bus.done) begin
            if (step_w.last || confirm_q) begin
              cmd_ready_o <= 1'b1;
              st_q <= S_IDLE;
            end else if (step_w.words) begin
              word_req_o <= 1'b1;
              st_q <= S_WORD;
            end else begin
              idx_q <= idx_q + 3'd1;
              st_q <= S_ISSUE;
            end
          end
        end
        S_WORD: begin
          if (take_word) begin
            word_req_o <= 1'b0;
            cyc_addr_q <= word_addr_i;
            cyc_data_q <= word_data_i;
            cyc_wr_q <= 1'b1;
            req_q <= 1'b1;
            left_q <= left_q - (CW + 1)'(1);
            st_q <= S_WWAIT;
          end
        end
        S_WWAIT: begin
          if (cyc_bus.done) begin
            if (left_q == '0) begin
              st_q <= S_CONFIRM;
            end else begin
              word_req_o <= 1'b1;
              st_q <= S_WORD;
            end
          end
        end
        S_CONFIRM: begin
          cyc_addr_q <= addr_q;
          cyc_data_q <= DW'(CODE_BUF_CONFIRM);
          cyc_wr_q <= 1'b1;
          req_q <= 1'b1;
          confirm_q <= 1'b1;
          st_q <= S_WAIT;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // results and tracked device state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      overlay_space_mode_o <= MODE_ARRAY;
      suspended_o <= 1'b0;
    end else begin
      rd_valid_o <= (st_q == S_WAIT) && cyc_bus.done && step_w.rd && !confirm_q;
      if ((st_q == S_WAIT) && cyc_bus.done && step_w.rd && !confirm_q) begin
        rd_data_o <= cyc_bus.rdata;
      end
      done_o <= seq_done;
      if (seq_done) begin
        overlay_space_mode_o <= mode_next_w;
        if (op_q == OP_SUSPEND) begin
          suspended_o <= 1'b1;
        end else if (op_q == OP_RESUME || op_q == OP_RESET) begin
          suspended_o <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bus-cycle engine
  // ----------------------------------------------------------------
  fcd_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .cyc(cyc_bus.eng),
    .flash_addr_o(flash_addr_o),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o),
    .flash_dq_i(flash_dq_i),
    .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o)
  );

endmodule // fcd_host

// file: logic/fcd_pkg.sv
/*
  Shared constants and types for the flash command sequencer (host side).
  Assumes a 100 MHz clock and a x16 asynchronous parallel NOR flash on the pins.
*/
package fcd_pkg;

  // ----------------------------------------------------------------
  // clock and bus timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int T_SETUP_NS = 10;
  localparam int T_PULSE_NS = 50;
  localparam int T_RECOVER_NS = 20;
  localparam int T_ACCESS_NS = 100;
  // least times round up, never below one cycle
  localparam int SETUP_RAW = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_RAW = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_RAW = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_RAW = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SETUP_CYC = 8'(SETUP_RAW < 1 ? 1 : SETUP_RAW);
  localparam logic [7:0] PULSE_CYC = 8'(PULSE_RAW < 1 ? 1 : PULSE_RAW);
  localparam logic [7:0] RECOVER_CYC = 8'(RECOVER_RAW < 1 ? 1 : RECOVER_RAW);
  localparam logic [7:0] ACCESS_CYC = 8'(ACCESS_RAW < 1 ? 1 : ACCESS_RAW);
  // cycles for a pin change to reach the third sync stage
  localparam logic [7:0] SYNC_CYC = 8'h03;

  // ----------------------------------------------------------------
  // fixed word addresses (low bits) and command codes
  // ----------------------------------------------------------------
  localparam int LOW_W = 12;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2aa;
  localparam logic [11:0] ADDR_QUERY = 12'h055;
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam logic [7:0] CODE_SR_READ = 8'h70;
  localparam logic [7:0] CODE_SR_CLEAR = 8'h71;
  localparam logic [7:0] CODE_PROGRAM = 8'ha0;
  localparam logic [7:0] CODE_BUF_LOAD = 8'h25;
  localparam logic [7:0] CODE_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
  localparam logic [7:0] CODE_QUERY_ENTRY = 8'h98;
  localparam logic [7:0] CODE_SECURE_ENTRY = 8'h88;
  localparam logic [7:0] CODE_SET_EXIT = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_SR_READ, OP_SR_CLEAR, OP_WORD_PROG, OP_BUF_PROG,
    OP_BUF_ABORT, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME,
    OP_ID_ENTRY, OP_QUERY_ENTRY, OP_SECURE_ENTRY, OP_SECURE_EXIT
  } fcd_op_t;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_SECURE} fcd_mode_t;

  typedef enum logic [2:0] {
    A_UNLOCK1, A_UNLOCK2, A_SECT_UNLOCK1, A_SECT_QUERY, A_USER
  } fcd_asel_t;

  typedef struct packed {
    logic rd;
    logic last;
    logic words;
    logic user_data;
    logic count_data;
    fcd_asel_t asel;
    logic [7:0] code;
  } fcd_step_t;

endpackage

// file: logic/fcd_cyc_if.sv
/*
  Carrier between the sequencer and its bus-cycle engine.
  Assumes both ends run on the same clock; req is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface fcd_cyc_if #(parameter int AW = 26, parameter int DW = 16);
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic done;
  logic [DW-1:0] rdata;

  modport ctrl (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface // fcd_cyc_if

// file: logic/fcd_cycle.sv
/*
  Bus-cycle engine: one asynchronous write or read cycle on the flash pins.
  Assumes requests arrive only while idle; data input pins are asynchronous.
*/
`timescale 1ns/1ps
module fcd_cycle import fcd_pkg::*; #(
  parameter int AW = 26,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  fcd_cyc_if.eng cyc,
  output logic [AW-1:0] flash_addr_o,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DW-1:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o
);

  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_PULSE, E_RECOVER, E_ACCESS, E_SAMPLE} fcd_eng_t;

  fcd_eng_t st_q;
  logic [7:0] cnt_q;
  logic [DW-1:0] s1_q, s2_q, s3_q;
  logic done_q;
  logic [DW-1:0] rdata_q;
  wire cnt_zero = (cnt_q == 8'h00);
  wire sync_stable = (s2_q == s3_q);

  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;

  // ----------------------------------------------------------------
  // data pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= flash_dq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= E_IDLE;
      cnt_q <= 8'h00;
      done_q <= 1'b0;
      rdata_q <= '0;
      flash_addr_o <= '0;
      flash_dq_o <= '0;
      flash_dq_oe_o <= 1'b0;
      flash_ce_n_o <= 1'b1;
      flash_oe_n_o <= 1'b1;
      flash_we_n_o <= 1'b1;
    end else begin
      done_q <= 1'b0;
      cnt_q <= cnt_zero ? 8'h00 : cnt_q - 8'h01;
      case (st_q)
        E_IDLE: begin
          if (cyc.req) begin
            flash_addr_o <= cyc.addr;
            flash_dq_o <= cyc.wdata;
            flash_ce_n_o <= 1'b0;
            flash_dq_oe_o <= cyc.wr;
            flash_oe_n_o <= cyc.wr;
            cnt_q <= cyc.wr ? SETUP_CYC - 8'h01 : ACCESS_CYC - 8'h01;
            st_q <= cyc.wr ? E_SETUP : E_ACCESS;
          end
        end
        E_SETUP: begin
          if (cnt_zero) begin
            flash_we_n_o <= 1'b0;
            cnt_q <= PULSE_CYC - 8'h01;
            st_q <= E_PULSE;
          end
        end
        E_PULSE: begin
          if (cnt_zero) begin
            flash_we_n_o <= 1'b1;
            cnt_q <= RECOVER_CYC - 8'h01;
            st_q <= E_RECOVER;
          end
        end
        E_RECOVER: begin
          if (cnt_zero) begin
            flash_ce_n_o <= 1'b1;
            flash_dq_oe_o <= 1'b0;
            done_q <= 1'b1;
            st_q <= E_IDLE;
          end
        end
        E_ACCESS: begin
          if (cnt_zero) begin
            cnt_q <= SYNC_CYC - 8'h01;
            st_q <= E_SAMPLE;
          end
        end
        E_SAMPLE: begin
          if (cnt_zero && sync_stable) begin
            rdata_q <= s3_q;
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            done_q <= 1'b1;
            st_q <= E_IDLE;
          end
        end
        default: st_q <= E_IDLE;
      endcase
    end
  end

endmodule // fcd_cycle

// file: tb/fcd_host_assertions.sv
/* Port assertions for the flash sequencer.
   Assumes one clock and an async active-low reset. */
`timescale 1ns/1ps
module fcd_host_chk import fcd_pkg::*; #(
  parameter int AW = 26,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i,
  input wire fcd_op_t cmd_op_i,
  input wire logic cmd_ready_o,
  input wire logic rd_valid_o,
  input wire logic done_o,
  input wire fcd_mode_t overlay_space_mode_o,
  input wire logic suspended_o,
  input wire logic [AW-1:0] flash_addr_o,
  input wire logic [DW-1:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire take = cmd_valid_i && cmd_ready_o;

  a_take_drops_ready: assert property (take |=> !cmd_ready_o) else $error("ready after take");
  a_done_pulse: assert property (done_o |=> !done_o) else $error("done too long");
  a_done_ready: assert property (done_o |-> cmd_ready_o) else $error("done without ready");
  a_read_done: assert property (rd_valid_o |-> done_o) else $error("read valid alone");
  a_write_strobes: assert property (!flash_we_n_o |-> (!flash_ce_n_o && flash_oe_n_o &&
    flash_dq_oe_o)) else $error("bad write strobe");
  a_write_hold: assert property ((!flash_we_n_o && !$past(flash_we_n_o)) |->
    ($stable(flash_addr_o) && $stable(flash_dq_o))) else $error("pins moved in pulse");
  a_reset_code:
    assert property ((take && cmd_op_i == OP_RESET) |-> ##[2:20]
      (!flash_we_n_o && flash_dq_o[7:0] == CODE_RESET)) else $error("no reset code");
  a_reset_mode:
    assert property ((take && cmd_op_i == OP_RESET) |-> ##[2:30]
      (done_o && overlay_space_mode_o == MODE_ARRAY)) else $error("mode not array");
  a_clear_cycle:
    assert property ((take && cmd_op_i == OP_SR_CLEAR) |-> ##[2:20] (!flash_we_n_o &&
      flash_addr_o[11:0] == ADDR_UNLOCK1 && flash_dq_o[7:0] == CODE_SR_CLEAR))
    else $error("bad clear cycle");
  a_suspend_set:
    assert property ((take && cmd_op_i == OP_SUSPEND) |-> ##[2:30] (done_o && suspended_o))
    else $error("suspend not set");
  a_resume_clear:
    assert property ((take && cmd_op_i == OP_RESUME) |-> ##[2:30] (done_o && !suspended_o))
    else $error("suspend not cleared");
endmodule // fcd_host_chk

bind fcd_host fcd_host_chk #(.AW(AW), .DW(DW)) u_chk (.*);

// file: tb/fcd_flash_model.sv
/* Flash command decoder model: array, overlays, status.
   Assumes writes latch on rising we_n while selected. */
`timescale 1ns/1ps
module fcd_flash_model import fcd_pkg::*; #(
  parameter int AW = 26,
  parameter int SL = 16
) (
  input wire logic [AW-1:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [logic [AW:0]];
  logic [15:0] bufm [logic [AW:0]];
  logic [AW:0] kq [$];
  logic [15:0] sr = 16'h00b0;
  logic [15:0] val;
  logic [15:0] last = '0;
  logic srn = 1'b0;
  int st = 0;
  int cnt = 0;
  fcd_mode_t md = MODE_ARRAY;
  wire [11:0] lo = addr_i[11:0];
  wire [7:0] d = dq_i[7:0];

  function automatic logic [AW:0] key(logic [AW-1:0] a);
    return {md == MODE_SECURE, a};
  endfunction

  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      if (d == CODE_RESET && !(st inside {3, 7, 8})) begin
        md = MODE_ARRAY;
        st = 0;
        bufm.delete();
      end else case (st)
        0: begin
          if (lo == ADDR_UNLOCK1 && d == CODE_UNLOCK1) st = 1;
          if (lo == ADDR_UNLOCK1 && d == CODE_SR_READ) srn = 1'b1;
          if (lo == ADDR_UNLOCK1 && d == CODE_SR_CLEAR) sr = 16'h0080;
          if (lo == ADDR_QUERY && d == CODE_QUERY_ENTRY) md = MODE_ID;
          if (d == CODE_BUF_CONFIRM) begin
            foreach (bufm[k]) mem[k] = bufm[k];
            bufm.delete();
          end
        end
        1: st = (lo == ADDR_UNLOCK2 && d == CODE_UNLOCK2) ? 2 : 0;
        2: begin
          st = d == CODE_PROGRAM ? 3 : d == CODE_BUF_LOAD ? 7 : d == CODE_ERASE_SETUP ? 4 :
            (d == CODE_ID_ENTRY && md == MODE_SECURE) ? 9 : 0;
          if (d == CODE_ID_ENTRY && md != MODE_SECURE) md = MODE_ID;
          if (d == CODE_SECURE_ENTRY) md = MODE_SECURE;
        end
        3: begin
          mem[key(addr_i)] = dq_i;
          st = 0;
        end
        4: st = (lo == ADDR_UNLOCK1 && d == CODE_UNLOCK1) ? 5 : 0;
        5: st = (lo == ADDR_UNLOCK2 && d == CODE_UNLOCK2) ? 6 : 0;
        6: begin
          if (d == CODE_CHIP_ERASE) mem.delete();
          kq.delete();
          foreach (mem[k]) if (d == CODE_SECTOR_ERASE && k[AW:SL] == {1'b0, addr_i[AW-1:SL]})
            kq.push_back(k);
          foreach (kq[i]) mem.delete(kq[i]);
          st = 0;
        end
        7: begin
          cnt = int'(d) + 1;
          st = 8;
        end
        8: begin
          bufm[key(addr_i)] = dq_i;
          cnt--;
          if (cnt == 0) st = 0;
        end
        9: begin
          if (dq_i == 16'h0) md = MODE_ARRAY;
          st = 0;
        end
        default: st = 0;
      endcase
    end
  end

  always @* begin
    if (srn) val = sr;
    else if (md == MODE_ID) val = {4'h9, lo};
    else if (mem.exists(key(addr_i))) val = mem[key(addr_i)];
    else val = {md == MODE_SECURE ? 4'h5 : 4'ha, lo};
    dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
  end

  always @(posedge oe_n_i) begin
    last = val;
    srn = 1'b0;
  end
endmodule // fcd_flash_model

// file: tb/tb_top.sv
/* Bench for the flash command sequencer.
   Assumes the flash model on the pins. */
`timescale 1ns/1ps
module tb_top import fcd_pkg::*;;
  logic clk_i = 1'b0, arst_n_i = 1'b0, cmd_valid_i = 1'b0, word_valid_i = 1'b0;
  fcd_op_t cmd_op_i = OP_READ;
  logic [25:0] cmd_addr_i = '0, word_addr_i = '0, flash_addr_o;
  logic [15:0] cmd_data_i = '0, word_data_i = '0, rd_data_o, flash_dq_o, flash_dq_i, got;
  logic [7:0] cmd_count_i = '0;
  logic cmd_ready_o, word_req_o, rd_valid_o, done_o, suspended_o, flash_dq_oe_o;
  logic flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
  fcd_mode_t overlay_space_mode_o;
  int err_count = 0, n_tests = 0, widx = 0;
  typedef struct {fcd_op_t op; logic [25:0] a; logic [15:0] d, x; fcd_mode_t m;} fcd_row_t;
  fcd_row_t rows [19] = '{
    '{OP_SR_READ, '0, '0, 16'h00b0, MODE_ARRAY}, '{OP_SR_CLEAR, '0, '0, '0, MODE_ARRAY},
    '{OP_SR_READ, '0, '0, 16'h0080, MODE_ARRAY},
    '{OP_WORD_PROG, 26'h10123, 16'h1234, '0, MODE_ARRAY},
    '{OP_READ, 26'h10123, '0, 16'h1234, MODE_ARRAY}, '{OP_ID_ENTRY, 26'h10000, '0, '0, MODE_ID},
    '{OP_READ, 26'h10042, '0, 16'h9042, MODE_ID}, '{OP_RESET, '0, '0, '0, MODE_ARRAY},
    '{OP_READ, 26'h10042, '0, 16'ha042, MODE_ARRAY},
    '{OP_QUERY_ENTRY, 26'h10000, '0, '0, MODE_ID}, '{OP_READ, 26'h10010, '0, 16'h9010, MODE_ID},
    '{OP_RESET, '0, '0, '0, MODE_ARRAY}, '{OP_SECURE_ENTRY, 26'h10000, '0, '0, MODE_SECURE},
    '{OP_WORD_PROG, 26'h77, 16'hbeef, '0, MODE_SECURE},
    '{OP_READ, 26'h77, '0, 16'hbeef, MODE_SECURE}, '{OP_SECURE_EXIT, '0, '0, '0, MODE_ARRAY},
    '{OP_READ, 26'h77, '0, 16'ha077, MODE_ARRAY}, '{OP_SUSPEND, '0, '0, 16'h1, MODE_ARRAY},
    '{OP_RESUME, '0, '0, '0, MODE_ARRAY}};

  fcd_host u_dut (.*);
  fcd_flash_model u_flash (.addr_i(flash_addr_o), .dq_i(flash_dq_o), .ce_n_i(flash_ce_n_o),
    .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .dq_o(flash_dq_i));

  initial forever #5 clk_i = ~clk_i;

  // buffer pairs offered one at a time
  always @(posedge clk_i) begin
    if (word_valid_i && word_req_o) begin
      widx <= widx + 1;
      word_valid_i <= 1'b0;
    end else if (word_req_o) begin
      word_valid_i <= 1'b1;
      word_addr_i <= 26'h20000 + 26'(widx);
      word_data_i <= 16'h3c00 + 16'(widx);
    end
  end

  task automatic chk(input logic [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmd(input fcd_op_t op, input logic [25:0] a, input logic [15:0] d = '0,
                     input logic [7:0] c = '0);
    int k;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    cmd_count_i <= c;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    for (k = 0; k < 3000 && done_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    if (k == 3000) chk(16'h0, 16'h1);
    got = rd_data_o;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op inside {OP_READ, OP_SR_READ}) chk(got, rows[i].x);
      chk(16'(overlay_space_mode_o), 16'(rows[i].m));
      if (rows[i].op inside {OP_SUSPEND, OP_RESUME}) chk(16'(suspended_o), rows[i].x);
      $display("row %0d done", i);
    end
    cmd(OP_BUF_PROG, 26'h20000, 16'h0, 8'h03);
    chk(16'(widx), 16'h4);
    cmd(OP_READ, 26'h20003);
    chk(got, 16'h3c03);
    cmd(OP_BUF_ABORT, 26'h0);
    cmd(OP_READ, 26'h20000);
    chk(got, 16'h3c00);
    cmd(OP_SECTOR_ERASE, 26'h10000);
    cmd(OP_READ, 26'h10123);
    chk(got, 16'ha123);
    cmd(OP_READ, 26'h20001);
    chk(got, 16'h3c01);
    cmd(OP_CHIP_ERASE, 26'h0);
    cmd(OP_READ, 26'h20001);
    chk(got, 16'ha001);
    $display("buffer test done");
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= OP_WORD_PROG;
    cmd_addr_i <= 26'h10200;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b0;
    #2;
    chk(16'(cmd_ready_o), 16'h1);
    chk(16'(flash_we_n_o), 16'h1);
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    cmd(OP_RESET, 26'h0);
    cmd(OP_READ, 26'h10200);
    chk(got, 16'ha200);
    $display("reset test done");
    stop_test();
  end

  initial begin
    #500000;
    err_count++;
    stop_test();
  end
endmodule // tb_top
